// ==== shared/fsac_pkg.sv ====
// fsac_pkg: constants, types for the fiber sensor acquisition control
// assumes a 50 MHz master clock; no register bus, settings are ports
package fsac_pkg;
  localparam int    CLK_PERIOD_NS = 20;
  localparam int    STEP_NS       = 10;
  localparam int    MIN_SPACE_NS  = 40;
  localparam int    MIN_SPACE_CYC =
    (MIN_SPACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int    N_SAMPLES     = 5;
  localparam int    N_SENSORS     = 16;
  localparam int    SENS_W        = 4;
  localparam int    POS_W         = 16;
  localparam int    GAIN_W        = 10;
  localparam int    GAIN_DEPTH    = 64;
  localparam int    GIDX_W        = 6;
  localparam int    GAIN_PACE     = 4;
  localparam int    TRIG_W        = 32;
  localparam int    ADC_W         = 16;
  localparam int    ANG_W         = 32;
  localparam int    WIDE_W        = 64;
  localparam int    DAC_W         = 24;
  localparam int    FRAC_KEEP     = 20;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 10'h3ff;
  localparam logic [DAC_W-1:0]  DAC_FULL = 24'h7fffff;
  localparam logic [DAC_W-1:0]  DAC_NEG  = 24'h800000;

  typedef enum logic [1:0] {
    FSAC_EDGE_RISE = 2'b00,
    FSAC_EDGE_FALL = 2'b01,
    FSAC_EDGE_BOTH = 2'b10
  } fsac_edge_type;

  typedef enum logic [2:0] {
    FSAC_SEL_PULSE0 = 3'b000,
    FSAC_SEL_PULSE1 = 3'b001,
    FSAC_SEL_AVG    = 3'b010,
    FSAC_SEL_ZERO   = 3'b011,
    FSAC_SEL_SQUARE = 3'b100,
    FSAC_SEL_SINE   = 3'b101
  } fsac_src_type;

  typedef struct packed {
    logic             valid;
    logic [SENS_W-1:0] sensor;
    logic [2:0]       index;
  } fsac_strobe_type;

  typedef struct packed {
    logic [ANG_W-1:0] pulse0;
    logic [ANG_W-1:0] pulse1;
  } fsac_angle_type;
endpackage : fsac_pkg

// ==== hdl/fsac_top.sv ====
// fsac_top: strobe placement, gain dac feed, level servo, trigger stamp,
// analog output path. assumes settings are static between table cycles.
// Contract
// - five strobes per return, one period apart
// - sample phase offsets all strobes in steps
// - per-sensor window adjust moves strobes
// - strobe spacing never below forty ns
// - adjust only window sensors; clears window/all
// - gain dac gets array entry plus adjust
// - new gain value every four clocks
// - host writes adjust only with servo off
// - servo integrates setpoint minus dark-corrected sum
// - enabled trigger edge latches time counter
// - counter from zero, divided master clock
// - counter wrap flagged for host
// - latched time copied to trailer, overwritten
// - angle sign-extended, filtered, 24 bits out
// - pulse1 and average only with two pulses
// - test modes zero, square, sinusoid
// - single-pole high-pass, zero cutoff bypasses
// - signed fringe shift, zero gives 4.20
`timescale 1ns/1ps
module fsac_top
  import fsac_pkg::*;
#(
  parameter int TABLE_LEN = 1000
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [POS_W-1:0]   sample_phase,
  input  wire logic [POS_W-1:0]   sample_period,
  input  wire logic [POS_W-1:0]   sensor_spacing,
  input  wire logic [SENS_W-1:0]  win_start,
  input  wire logic [SENS_W-1:0]  win_end,
  input  wire logic signed [7:0]  win_adjust,
  input  wire logic               win_adjust_load,
  input  wire logic               win_clear,
  input  wire logic               win_clear_all,
  input  wire logic               gain_wr,
  input  wire logic [GIDX_W-1:0]  gain_wr_idx,
  input  wire logic [GAIN_W-1:0]  gain_wr_data,
  input  wire logic signed [GAIN_W:0] gain_adjust_wr,
  input  wire logic               gain_adjust_we,
  input  wire logic               servo_en,
  input  wire logic [7:0]         level_servo_gain,
  input  wire logic [ADC_W+1:0]   level_servo_setpoint,
  input  wire logic [ADC_W-1:0]   dark_level,
  input  wire logic               mask_valid,
  input  wire logic [ADC_W-1:0]   mask_s0,
  input  wire logic [ADC_W-1:0]   mask_s1,
  input  wire logic [ADC_W-1:0]   mask_s2,
  input  wire logic               trig_en,
  input  wire fsac_edge_type      trig_sel,
  input  wire logic [15:0]        trig_div,
  input  wire logic               trig_pin,
  input  wire logic               frame_end,
  input  wire logic               aout_en,
  input  wire fsac_src_type       aout_sel,
  input  wire logic [1:0]         pulses_per_cycle,
  input  wire logic               angle_valid,
  input  wire fsac_angle_type     angle_in,
  input  wire logic               mod_slope,
  input  wire logic [DAC_W-1:0]   sine_in,
  input  wire logic [4:0]         hpf_cutoff,
  input  wire logic signed [6:0]  fringe_shift,
  input  wire logic               dac_ready,
  output fsac_strobe_type         strobe,
  output logic [GAIN_W-1:0]       gain_dac,
  output logic signed [GAIN_W:0]  receiver_gain_offset,
  output logic [TRIG_W-1:0]       trailer_time,
  output logic                    trailer_trig,
  output logic                    time_wrap,
  output logic [DAC_W-1:0]        dac_data,
  output logic                    dac_valid,
  output logic                    aout_ready
);
  // ****************************************************************
  // table position and strobe placement
  // ****************************************************************
  logic [POS_W-1:0]        pos_q, pos_d;
  logic [POS_W-1:0]        next_q, next_d;
  logic [SENS_W-1:0]       sens_q, sens_d;
  logic [2:0]              idx_q, idx_d;
  logic                    done_q, done_d;
  logic signed [7:0]       adj_q [N_SENSORS];
  fsac_strobe_type         strobe_q;
  wire logic table_wrap =
    pos_q == POS_W'((TABLE_LEN - 1) * CLK_PERIOD_NS / STEP_NS);
  wire logic [POS_W-1:0] steps_per_clk = POS_W'(CLK_PERIOD_NS / STEP_NS);
  wire logic [POS_W-1:0] min_step = POS_W'(MIN_SPACE_NS / STEP_NS);
  wire logic [POS_W-1:0] period_eff =
    sample_period < min_step ? min_step : sample_period;
  wire logic hit = !done_q && pos_q >= next_q;
  wire logic last_sample = idx_q == 3'(N_SAMPLES - 1);
  wire logic last_sensor = sens_q == SENS_W'(N_SENSORS - 1);
  wire logic [SENS_W-1:0] sens_nx = sens_q + SENS_W'(1);

  // nominal start of a sensor plus its signed window trim
  function automatic logic [POS_W-1:0] sensor_base(
    input logic [SENS_W-1:0] s, input logic signed [7:0] a);
    logic [POS_W-1:0] nom;
    nom = sample_phase + POS_W'(s * sensor_spacing);
    return nom + POS_W'(signed'(a));
  endfunction : sensor_base

  wire logic [POS_W-1:0] base_nx = sensor_base(sens_nx, adj_q[sens_nx]);
  wire logic [POS_W-1:0] tail = next_q + period_eff;
  wire logic [POS_W-1:0] gap_nx = base_nx < tail ? tail : base_nx;

  always_comb begin
    pos_d  = table_wrap ? '0 : pos_q + steps_per_clk;
    next_d = next_q;
    sens_d = sens_q;
    idx_d  = idx_q;
    done_d = done_q;
    if (table_wrap) begin
      next_d = sensor_base('0, adj_q[0]);
      sens_d = '0;
      idx_d  = '0;
      done_d = 1'b0;
    end else if (hit) begin
      if (!last_sample) begin
        idx_d  = idx_q + 3'd1;
        next_d = next_q + period_eff;
      end else if (last_sensor) begin
        done_d = 1'b1;
      end else begin
        idx_d  = '0;
        sens_d = sens_nx;
        next_d = gap_nx;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pos_q    <= '0;
      next_q   <= '0;
      sens_q   <= '0;
      idx_q    <= '0;
      done_q   <= 1'b0;
      strobe_q <= '0;
    end else begin
      pos_q    <= pos_d;
      next_q   <= next_d;
      sens_q   <= sens_d;
      idx_q    <= idx_d;
      done_q   <= done_d;
      strobe_q <= '{valid: hit, sensor: sens_q, index: idx_q};
    end
  end
  assign strobe = strobe_q;

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N_SENSORS; i++) begin
      if (reset || win_clear_all) begin
        adj_q[i] <= '0;
      end else if (SENS_W'(i) >= win_start && SENS_W'(i) <= win_end) begin
        if (win_clear) begin
          adj_q[i] <= '0;
        end else if (win_adjust_load) begin
          adj_q[i] <= win_adjust;
        end
      end
    end
  end

  // ****************************************************************
  // gain array, adjust and level servo
  // ****************************************************************
  logic [GAIN_W-1:0]       gain_mem [GAIN_DEPTH];
  logic [GIDX_W-1:0]       gidx_q;
  logic [1:0]              pace_q;
  logic [GAIN_W-1:0]       gain_q;
  logic signed [GAIN_W:0]  goff_q, goff_d;
  wire logic pace_hit = pace_q == 2'(GAIN_PACE - 1);
  wire logic signed [GAIN_W+1:0] gsum =
    $signed({2'b00, gain_mem[gidx_q]}) + (GAIN_W+2)'(goff_q);
  wire logic [GAIN_W-1:0] gsat = gsum < 0 ? '0 :
    gsum > $signed({2'b00, GAIN_MAX}) ? GAIN_MAX : gsum[GAIN_W-1:0];
  wire logic signed [ADC_W+3:0] msum =
    (ADC_W+4)'(mask_s0) + (ADC_W+4)'(mask_s1) + (ADC_W+4)'(mask_s2) -
    (ADC_W+4)'(3 * dark_level);
  wire logic signed [ADC_W+4:0] err =
    $signed({3'b000, level_servo_setpoint}) - (ADC_W+5)'(msum);
  wire logic signed [ADC_W+13:0] corr =
    (ADC_W+14)'(err) * $signed({1'b0, level_servo_gain});
  wire logic signed [ADC_W+13:0] goff_new =
    (ADC_W+14)'(goff_q) + (corr >>> ADC_W);
  wire logic signed [ADC_W+13:0] goff_hi = (ADC_W+14)'(10'sh1ff * 2 + 1);

  always_comb begin
    goff_d = goff_q;
    if (servo_en && mask_valid) begin
      if (goff_new > goff_hi) begin
        goff_d = goff_hi[GAIN_W:0];
      end else if (goff_new < -goff_hi) begin
        goff_d = -goff_hi[GAIN_W:0];
      end else begin
        goff_d = goff_new[GAIN_W:0];
      end
    end else if (!servo_en && gain_adjust_we) begin
      goff_d = gain_adjust_wr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gain_mem <= '{default: '0};
    end else if (gain_wr) begin
      gain_mem[gain_wr_idx] <= gain_wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gidx_q <= '0;
      pace_q <= '0;
      gain_q <= '0;
      goff_q <= '0;
    end else begin
      goff_q <= goff_d;
      pace_q <= pace_q + 2'd1;
      if (pace_hit) begin
        gain_q <= gsat;
      end
      // gain walk restarts with the table
      if (pace_hit || table_wrap) begin
        gidx_q <= table_wrap ? '0 : gidx_q + GIDX_W'(1);
      end
    end
  end
  assign gain_dac = gain_q;
  assign receiver_gain_offset = goff_q;

  // ****************************************************************
  // trigger time stamp
  // ****************************************************************
  logic [2:0]        trig_sync_q;
  logic [15:0]       div_q;
  logic [TRIG_W-1:0] time_q, latch_q, trail_q;
  logic              wrap_q, seen_q, tflag_q;
  wire logic rise = trig_sync_q[1] && !trig_sync_q[2];
  wire logic fall = !trig_sync_q[1] && trig_sync_q[2];
  wire logic edge_hit = trig_en && (
    (trig_sel == FSAC_EDGE_RISE && rise) ||
    (trig_sel == FSAC_EDGE_FALL && fall) ||
    (trig_sel == FSAC_EDGE_BOTH && (rise || fall)));
  wire logic tick = div_q + 16'd1 >= trig_div;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trig_sync_q <= '0;
      div_q       <= '0;
      time_q      <= '0;
      latch_q     <= '0;
      trail_q     <= '0;
      wrap_q      <= 1'b0;
      seen_q      <= 1'b0;
      tflag_q     <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_pin};
      div_q       <= tick ? '0 : div_q + 16'd1;
      if (tick) begin
        time_q <= time_q + TRIG_W'(1);
      end
      if (tick && &time_q) begin
        wrap_q <= 1'b1;
      end
      if (edge_hit) begin
        latch_q <= time_q;
      end
      if (frame_end) begin
        trail_q <= edge_hit ? time_q : latch_q;
        tflag_q <= seen_q || edge_hit;
        seen_q  <= 1'b0;
      end else if (edge_hit) begin
        seen_q <= 1'b1;
      end
    end
  end
  assign trailer_time = trail_q;
  assign trailer_trig = tflag_q;
  assign time_wrap    = wrap_q;

  // ****************************************************************
  // analog output: source, high-pass, shift, two-entry buffer
  // ****************************************************************
  logic signed [WIDE_W-1:0] hp_y_q, hp_x_q;
  logic [DAC_W-1:0]         buf_q [2];
  logic                     wp_q, rp_q;
  logic [1:0]               cnt_q;
  wire logic two_p = pulses_per_cycle == 2'd2;
  wire logic [ANG_W-1:0] ang =
    (aout_sel == FSAC_SEL_PULSE1 && two_p) ? angle_in.pulse1 :
    (aout_sel == FSAC_SEL_AVG && two_p) ?
      ANG_W'(($signed({angle_in.pulse0[ANG_W-1], angle_in.pulse0}) +
              $signed({angle_in.pulse1[ANG_W-1], angle_in.pulse1})) >>> 1) :
    angle_in.pulse0;
  wire logic signed [WIDE_W-1:0] x64 = WIDE_W'(signed'(ang));
  // y = a*(y + x - x_prev), a = 1 - 2^-k
  wire logic signed [WIDE_W-1:0] hp_s = hp_y_q + x64 - hp_x_q;
  wire logic signed [WIDE_W-1:0] hp_n = hp_s - (hp_s >>> hpf_cutoff);
  wire logic signed [WIDE_W-1:0] filt = hpf_cutoff == '0 ? x64 : hp_n;
  wire logic [6:0] sh_mag =
    fringe_shift[6] ? 7'(-fringe_shift) : 7'(fringe_shift);
  // fringe shift, 4 fringe bits over 20 angle bits
  wire logic signed [WIDE_W-1:0] shf =
    fringe_shift[6] ? filt >>> sh_mag : filt <<< sh_mag;
  wire logic [DAC_W-1:0] ang_out = shf[ANG_W-1 -: DAC_W];
  wire logic [DAC_W-1:0] src =
    aout_sel == FSAC_SEL_ZERO   ? '0 :
    aout_sel == FSAC_SEL_SQUARE ? (mod_slope ? DAC_FULL : DAC_NEG) :
    aout_sel == FSAC_SEL_SINE   ? sine_in : ang_out;
  wire logic full = cnt_q == 2'd2;
  wire logic push = aout_en && angle_valid && !full;
  wire logic pop  = dac_valid && dac_ready;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hp_y_q <= '0;
      hp_x_q <= '0;
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      cnt_q  <= '0;
      buf_q  <= '{default: '0};
    end else begin
      if (push) begin
        hp_y_q     <= hp_n;
        hp_x_q     <= x64;
        buf_q[wp_q] <= src;
        wp_q       <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dac_valid  <= 1'b0;
      aout_ready <= 1'b0;
      dac_data   <= '0;
    end else begin
      dac_valid  <= cnt_q + 2'(push) - 2'(pop) != 2'd0;
      aout_ready <= cnt_q + 2'(push) - 2'(pop) != 2'd2;
      dac_data   <= (pop || !dac_valid) ?
        ((cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) && push ? src :
         buf_q[pop ? !rp_q : rp_q]) : dac_data;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // gain cadence
  chk_gain_pace: assert property (@(posedge sys_clk) disable iff (reset)
    !pace_hit |=> !$changed(gain_dac))
    else $error("gain dac changed off cadence");
  chk_gain_sat: assert property (@(posedge sys_clk) disable iff (reset)
    pace_hit && gsum < 0 |=> gain_dac == '0)
    else $error("gain sum not clamped low");
  chk_adjust_lock: assert property (@(posedge sys_clk) disable iff (reset)
    !servo_en && !$past(servo_en) && gain_adjust_we |=>
      receiver_gain_offset == $past(gain_adjust_wr))
    else $error("host adjust write lost");
  chk_servo_hold: assert property (@(posedge sys_clk) disable iff (reset)
    servo_en && !mask_valid |=> $stable(receiver_gain_offset))
    else $error("servo moved without samples");
  chk_trig_latch: assert property (@(posedge sys_clk) disable iff (reset)
    edge_hit && !frame_end |=> latch_q == $past(time_q))
    else $error("trigger time not latched");
  chk_trig_off: assert property (@(posedge sys_clk) disable iff (reset)
    !trig_en && !seen_q && frame_end |=> !trailer_trig)
    else $error("trigger taken while disabled");
  chk_time_count: assert property (@(posedge sys_clk) disable iff (reset)
    tick |=> time_q == $past(time_q) + 32'h1)
    else $error("time counter did not step");
  chk_strobe_gap: assert property (@(posedge sys_clk) disable iff (reset)
    strobe.valid |=> !strobe.valid)
    else $error("strobes closer than minimum");
  chk_table_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    table_wrap |=> pos_q == '0 && sens_q == '0)
    else $error("table position not restarted");
  chk_buf_full: assert property (@(posedge sys_clk) disable iff (reset)
    full |-> !aout_ready)
    else $error("buffer full but ready high");
endmodule : fsac_top

// ==== tb/fsac_dac_sink.sv ====
// fsac_dac_sink: output dac model on the valid/ready side of the block
// assumes one clock; stall and slow pacing are set by the bench
`timescale 1ns/1ps
module fsac_dac_sink
  import fsac_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             stall,
  input  wire logic             slow,
  input  wire logic             dac_valid,
  input  wire logic [DAC_W-1:0] dac_data,
  output logic                  dac_ready,
  output logic [DAC_W-1:0]      last_word,
  output logic [7:0]            word_count
);
  logic toggle_q;

  // ****************************************
  // acceptance
  // ****************************************
  // slow mode takes a word every other clock
  assign dac_ready = !stall && (!slow || toggle_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      toggle_q   <= 1'b0;
      last_word  <= '0;
      word_count <= '0;
    end else begin
      toggle_q <= !toggle_q;
      if (dac_valid && dac_ready) begin
        last_word  <= dac_data;
        word_count <= word_count + 8'h01;
      end
    end
  end
endmodule : fsac_dac_sink

// ==== tb/fsac_top_tb.sv ====
// fsac_top_tb: self-checking bench for the acquisition control block
// assumes fsac_pkg, fsac_top and the dac sink model are compiled first
`timescale 1ns/1ps
module fsac_top_tb
  import fsac_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  typedef struct packed {
    fsac_src_type      sel;
    logic [1:0]        ppc;
    logic [ANG_W-1:0]  p0;
    logic [ANG_W-1:0]  p1;
    logic signed [6:0] sh;
    logic              slope;
    logic [DAC_W-1:0]  exp_v;
  } fsac_row_type;
  localparam int TIMEOUT = 40000;
  logic                   sys_clk = 1'b0;
  logic                   reset = 1'b1;
  // single unit keeps sample phase zero
  logic [POS_W-1:0]       sample_phase = '0;
  // minimum sample period of four steps
  logic [POS_W-1:0]       sample_period = 16'h0004;
  logic [POS_W-1:0]       sensor_spacing = 16'h0018;
  logic [SENS_W-1:0]      win_start = '0, win_end = '0;
  logic signed [7:0]      win_adjust = '0;
  logic                   win_adjust_load = 1'b0, win_clear = 1'b0;
  logic                   win_clear_all = 1'b0, gain_wr = 1'b0;
  logic                   gain_adjust_we = 1'b0, servo_en = 1'b0;
  logic [GIDX_W-1:0]      gain_wr_idx = '0;
  logic [GAIN_W-1:0]      gain_wr_data = '0;
  logic signed [GAIN_W:0] gain_adjust_wr = '0;
  logic [7:0]             level_servo_gain = 8'hff;
  logic [ADC_W+1:0]       level_servo_setpoint = '0;
  logic [ADC_W-1:0]       dark_level = '0, mask_s0 = '0;
  logic [ADC_W-1:0]       mask_s1 = '0, mask_s2 = '0;
  logic                   mask_valid = 1'b0, trig_en = 1'b0;
  logic                   trig_pin = 1'b0, frame_end = 1'b0;
  fsac_edge_type          trig_sel = FSAC_EDGE_RISE;
  logic [15:0]            trig_div = 16'h0001;
  logic                   aout_en = 1'b1, angle_valid = 1'b0;
  logic                   mod_slope = 1'b0, stall = 1'b0, slow = 1'b0;
  fsac_src_type           aout_sel = FSAC_SEL_ZERO;
  logic [1:0]             pulses_per_cycle = 2'h1;
  fsac_angle_type         angle_in = '0;
  logic [DAC_W-1:0]       sine_in = 24'h2a5a5a;
  logic [4:0]             hpf_cutoff = '0;
  logic signed [6:0]      fringe_shift = '0;
  logic                   dac_ready, trailer_trig, time_wrap;
  logic                   dac_valid, aout_ready;
  fsac_strobe_type        strobe;
  logic [GAIN_W-1:0]      gain_dac;
  logic signed [GAIN_W:0] receiver_gain_offset;
  logic [TRIG_W-1:0]      trailer_time;
  logic [DAC_W-1:0]       dac_data, last_word;
  logic [7:0]             word_count;
  int                     fail_count = 0, total_checks = 0, cyc = 0;
  fsac_row_type rows [10] = '{
    '{FSAC_SEL_PULSE0, 2'h1, 32'h12345678, 32'h0, 7'h00, 1'b0, 24'h123456},
    '{FSAC_SEL_PULSE0, 2'h1, 32'h12345678, 32'h0, 7'h04, 1'b0, 24'h234567},
    '{FSAC_SEL_PULSE0, 2'h1, 32'hf0000000, 32'h0, 7'h7c, 1'b0, 24'hff0000},
    '{FSAC_SEL_PULSE1, 2'h2, 32'h0, 32'h0abcdef0, 7'h00, 1'b0, 24'h0abcde},
    '{FSAC_SEL_AVG, 2'h2, 32'h10000000, 32'h30000000, 7'h00, 1'b0, 24'h200000},
    '{FSAC_SEL_ZERO, 2'h1, 32'h12345678, 32'h0, 7'h00, 1'b0, 24'h000000},
    '{FSAC_SEL_SQUARE, 2'h1, 32'h0, 32'h0, 7'h00, 1'b1, 24'h7fffff},
    '{FSAC_SEL_SQUARE, 2'h1, 32'h0, 32'h0, 7'h00, 1'b0, 24'h800000},
    '{FSAC_SEL_SINE, 2'h1, 32'h0, 32'h0, 7'h00, 1'b0, 24'h2a5a5a},
    '{FSAC_SEL_PULSE1, 2'h1, 32'h12345678, 32'h0, 7'h00, 1'b0, 24'h123456}};
  logic [GAIN_W-1:0]      g_ent [3] = '{10'h0c8, 10'h3ff, 10'h002};
  logic signed [GAIN_W:0] g_adj [3] = '{11'h025, 11'h005, 11'h7fb};
  logic [GAIN_W-1:0]      g_exp [3] = '{10'h0ed, 10'h3ff, 10'h000};
  fsac_edge_type t_sel [4] = '{FSAC_EDGE_RISE, FSAC_EDGE_FALL,
                               FSAC_EDGE_BOTH, FSAC_EDGE_RISE};
  int            t_gap [4] = '{54, 94, 54, 14};

  fsac_top #(.TABLE_LEN(400)) i_dut (.*);
  fsac_dac_sink i_sink (.*);

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      fail_count++;
      give_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [63:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check

  task automatic push(input fsac_row_type r);
    @(posedge sys_clk);
    aout_sel         <= r.sel;
    pulses_per_cycle <= r.ppc;
    angle_in         <= {r.p0, r.p1};
    fringe_shift     <= r.sh;
    mod_slope        <= r.slope;
    angle_valid      <= 1'b1;
    @(posedge sys_clk);
    angle_valid <= 1'b0;
  endtask : push

  task automatic dac_wait(input logic [7:0] n);
    int k = 0;
    while (word_count !== n && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    check("dac_count", n, word_count);
  endtask : dac_wait

  task automatic st_wait(input int s, i);
    int n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(strobe.valid === 1'b1 && strobe.sensor === SENS_W'(s)
                 && strobe.index === 3'(i)) && n < 900);
  endtask : st_wait

  task automatic gap_chk(input int sa, ia, sb, ib, e);
    int c0;
    st_wait(sa, ia);
    c0 = cyc;
    st_wait(sb, ib);
    check("strobe_gap", e, cyc - c0);
  endtask : gap_chk

  task automatic win_op(input int s, e, input logic [7:0] a,
                        input logic [2:0] op);
    @(posedge sys_clk);
    win_start       <= SENS_W'(s);
    win_end         <= SENS_W'(e);
    win_adjust      <= a;
    win_adjust_load <= op[0];
    win_clear       <= op[1];
    win_clear_all   <= op[2];
    @(posedge sys_clk);
    {win_adjust_load, win_clear, win_clear_all} <= 3'b000;
    repeat (400) @(posedge sys_clk);
  endtask : win_op

  task automatic gain_fill(input logic ramp, input logic [GAIN_W-1:0] v);
    for (int k = 0; k < GAIN_DEPTH; k++) begin
      @(posedge sys_clk);
      gain_wr      <= 1'b1;
      gain_wr_idx  <= GIDX_W'(k);
      gain_wr_data <= ramp ? GAIN_W'(k) : v;
    end
    @(posedge sys_clk);
    gain_wr <= 1'b0;
  endtask : gain_fill

  task automatic set_adj(input logic [GAIN_W:0] v);
    @(posedge sys_clk);
    gain_adjust_we <= 1'b1;
    gain_adjust_wr <= v;
    @(posedge sys_clk);
    gain_adjust_we <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : set_adj

  task automatic mask_pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      mask_valid <= 1'b1;
      @(posedge sys_clk);
      mask_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    @(negedge sys_clk);
  endtask : mask_pulses

  task automatic trig_shot(input logic en, input fsac_edge_type sel,
                           input int gap, output logic [TRIG_W-1:0] t);
    repeat (gap + 1) @(posedge sys_clk);
    trig_en  <= en;
    trig_sel <= sel;
    trig_pin <= 1'b1;
    repeat (40) @(posedge sys_clk);
    trig_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    frame_end <= 1'b1;
    @(posedge sys_clk);
    frame_end <= 1'b0;
    repeat (3) @(negedge sys_clk);
    t = trailer_time;
  endtask : trig_shot

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    logic [TRIG_W-1:0] t0, t1;
    logic [GAIN_W-1:0] prev;
    logic [7:0]        n;
    fsac_row_type      r;
    int                run, seen;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check("reset_gain", 0, gain_dac);
    check("reset_valid", 0, dac_valid);
    foreach (rows[i]) begin
      n = word_count;
      push(rows[i]);
      dac_wait(n + 8'h01);
      check("dac_data", rows[i].exp_v, last_word);
    end
    // stalled sink: two words held, third dropped
    stall <= 1'b1;
    n = word_count;
    r = rows[0];
    for (int k = 1; k < 4; k++) begin
      r.p0 = 32'h01000000 * k;
      push(r);
    end
    @(negedge sys_clk);
    check("aout_ready", 0, aout_ready);
    stall <= 1'b0;
    slow <= 1'b1;
    dac_wait(n + 8'h02);
    repeat (10) @(negedge sys_clk);
    check("dac_drop", n + 8'h02, word_count);
    check("dac_order", 24'h020000, last_word);
    slow       <= 1'b0;
    hpf_cutoff <= 5'h01;
    n = word_count;
    repeat (40) push(rows[0]);
    dac_wait(n + 8'd40);
    check("hpf_dc", 0, last_word);
    gap_chk(0, 0, 0, 1, 2);
    gap_chk(0, 0, 0, 4, 8);
    gap_chk(0, 0, 1, 0, 12);
    win_op(1, 2, 8'h04, 3'b001);
    gap_chk(0, 0, 1, 0, 14);
    gap_chk(1, 0, 1, 4, 8);
    gap_chk(2, 4, 3, 0, 2);
    win_op(1, 2, 8'h00, 3'b010);
    gap_chk(0, 0, 1, 0, 12);
    win_op(1, 2, 8'h04, 3'b001);
    win_op(0, 0, 8'h00, 3'b100);
    gap_chk(0, 0, 1, 0, 12);
    gain_fill(1'b1, '0);
    set_adj('0);
    st_wait(0, 0);
    prev = gain_dac;
    run = 0;
    seen = 0;
    repeat (300) begin
      @(negedge sys_clk);
      if (gain_dac !== prev) begin
        if (seen > 0) check("gain_step", (prev + 10'h001) & 10'h03f, gain_dac);
        if (seen > 1) check("gain_pace", GAIN_PACE, run);
        seen++;
        run = 0;
        prev = gain_dac;
      end
      run++;
    end
    for (int k = 0; k < 3; k++) begin
      gain_fill(1'b0, g_ent[k]);
      set_adj(g_adj[k]);
      check("adj_taken", {g_adj[k]}, {receiver_gain_offset});
      repeat (300) @(negedge sys_clk);
      check("gain_dac", g_exp[k], gain_dac);
    end
    @(posedge sys_clk);
    servo_en <= 1'b1;
    // setpoint at a quarter of full scale
    level_servo_setpoint <= 18'h10000;
    set_adj(11'h123);
    check("adj_refused", 11'h7fb, {receiver_gain_offset});
    mask_pulses(6);
    check("servo_up", 11'h3ff, {receiver_gain_offset});
    @(posedge sys_clk);
    level_servo_setpoint <= '0;
    {mask_s0, mask_s1, mask_s2} <= {3{16'hffff}};
    mask_pulses(6);
    check("servo_down", 11'h401, {receiver_gain_offset});
    @(posedge sys_clk);
    dark_level <= 16'h03e8;
    {mask_s0, mask_s1, mask_s2} <= {3{16'h03e8}};
    mask_pulses(3);
    check("servo_dark", 11'h401, {receiver_gain_offset});
    trig_shot(1'b1, FSAC_EDGE_RISE, 0, t0);
    for (int k = 0; k < 4; k++) begin
      trig_shot(1'b1, t_sel[k], 0, t1);
      check("trig_time", t_gap[k], t1 - t0);
      check("trig_flag", 1, trailer_trig);
      t0 = t1;
    end
    trig_shot(1'b0, FSAC_EDGE_RISE, 0, t1);
    check("trig_off", 0, trailer_trig);
    trig_div <= 16'h0019;
    trig_shot(1'b1, FSAC_EDGE_RISE, 0, t0);
    trig_shot(1'b1, FSAC_EDGE_RISE, 196, t1);
    check("trig_div", 10, t1 - t0);
    check("no_wrap", 0, time_wrap);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check("reset_offset", 0, {receiver_gain_offset});
    check("reset_time", 0, trailer_time);
    give_verdict();
  end
endmodule : fsac_top_tb
